// [sleep_pkg.sv]
/*
 * Sleep controller package: register offsets, field positions, reset
 * values, sleep mode codes, controller states and wake-up timing.
 * Assumes nothing of its surroundings; imported by the sleep controller.
 */
package sleep_pkg;

	// register byte addresses on the Avalon-MM slave
	localparam logic [3:0] sleep_control_off = 4'h0;
	localparam logic [3:0] peripheral_gate_off = 4'h4;
	localparam logic [3:0] sleep_status_off = 4'h8;

	// sleep_control_reg fields and the reset values of both registers
	localparam int sleep_allow_pos = 0;
	localparam int sleep_select_lsb = 1;
	localparam logic [7:0] sleep_control_rst = 8'h00;
	localparam logic [6:0] peripheral_gate_rst = 7'h00;

	// gate bit positions in peripheral_clock_gate_reg
	localparam int gate_adc_pos = 0;
	localparam int gate_lin_pos = 1;
	localparam int gate_spi_pos = 2;
	localparam int gate_tim0_pos = 3;
	localparam int gate_tim1_pos = 4;
	localparam int gate_psc_pos = 5;
	localparam int gate_can_pos = 6;

	localparam logic [2:0] mode_idle = 3'h0;
	localparam logic [2:0] mode_adc_nr = 3'h1;
	localparam logic [2:0] mode_power_down = 3'h2;
	localparam logic [2:0] mode_standby = 3'h6;

	// wake-up timing in core clock cycles
	localparam int standby_wake_cycles = 6;
	localparam int halt_extra_cycles = 4;

	typedef enum logic [4:0] {
		st_active = 5'b0_0001,
		st_sleep = 5'b0_0010,
		st_startup = 5'b0_0100,
		st_halt = 5'b0_1000,
		st_resume = 5'b1_0000
	} ctl_state_type;

endpackage

// [sleep_ctl.sv]
/*
 * Sleep controller: sleep entry, per-mode clock domain gating, wake-up
 * source filtering, start-up delay and per-peripheral clock gating.
 * Assumes a core that raises sleep_instr for one cycle on a sleep
 * instruction and waits for resume, and clock-gate cells downstream
 * that latch their enables on the low phase of each gated clock.
 */
// Design decisions made here: the register addresses and the Avalon-MM interface to the registers.
// Contract
// - sleep happens only when sleep-allow bit set at sleep instruction
// - code 000 idle: stop cpu and flash clocks only
// - code 001 adc noise reduction: stop io, cpu, flash clocks
// - in adc noise reduction timers run only from external clock pins
// - code 010 power-down: oscillator and all generated clocks stop
// - code 110 standby needs crystal option; oscillator keeps running
// - standby start-up ends six cycles after wake condition
// - interrupt wake halts core four cycles beyond start-up, then services
// - register file and sram contents survive wake-up
// - reset during sleep wakes core to reset vector
// - idle honours every wake source
// - adc noise reduction wakes only on listed sources, level external
// - power-down wakes on resets, power stage, level external only
// - power-down wake delayed by fuse-selected reset time-out
// - entering idle or adc noise reduction starts adc conversion
// - pll runs in idle and adc nr; main source off in power-down
// - set gate bit stops peripheral clock and blocks its io access
// - clear gate bit restarts peripheral in its prior state
// - gate bits matter only in active and idle modes
// - codes 011, 100, 101, 111 reserved
// - one gate bit per peripheral: can, psc, timers, spi, lin, adc
`timescale 1ns/1ps
module sleep_ctl
	import sleep_pkg::*;
#(
	parameter int startup_cycles = 16384, // fuse-selected reset time-out
	parameter int count_width = 16
) (
	input wire logic mclk, // 250 MHz core clock
	input wire logic rst_n, // synchronous reset, active low
	input wire logic [3:0] avs_address, // byte address
	input wire logic avs_read, // read request
	input wire logic avs_write, // write request
	input wire logic [31:0] avs_writedata, // write data
	output logic [31:0] avs_readdata, // read data
	output logic avs_waitrequest, // stall
	input wire logic sleep_instr, // core executes sleep, one pulse
	input wire logic crystal_selected, // external crystal clock option
	input wire logic adc_enabled, // adc enable from adc block
	input wire logic [3:0] external_irq_lines, // raw external irq levels
	input wire logic [3:0] ext_irq_level_mode, // 1: line is level type
	input wire logic [3:0] ext_irq_pending, // enabled external irq flags
	input wire logic power_stage_ctl_irq, // power stage controller irq
	input wire logic self_program_op_irq, // self-program/eeprom ready
	input wire logic adc_done_irq, // adc conversion complete
	input wire logic watchdog_unit_irq, // watchdog interrupt
	input wire logic timer_irq, // timer/counter interrupts
	input wire logic other_io_irq, // other i/o interrupts
	input wire logic wake_reset, // external, watchdog or brown-out reset
	output logic cpu_clk_en, // cpu clock enable
	output logic flash_clk_en, // flash clock enable
	output logic io_clk_en, // i/o clock enable
	output logic adc_clk_en, // adc clock enable
	output logic pll_clk_en, // pll clock enable
	output logic main_osc_en, // main clock source enable
	output logic timer_ext_only, // timers limited to pin clocks
	output logic [6:0] periph_clk_en, // per-peripheral clock enables
	output logic [6:0] periph_io_block, // block peripheral register access
	output logic adc_auto_start, // start adc conversion, one pulse
	output logic core_halt, // core held in sleep or wake delay
	output logic resume_pulse, // core resumes after sleep, one pulse
	output logic reset_wake // reset seen in sleep, restart at vector
);

	// refuse a counter too narrow for the fuse-selected time-out
	if (count_width < 4 || startup_cycles < 1 ||
		startup_cycles >= (1 << count_width)) begin : bad_params
		$error("sleep_ctl: bad count parameters");
	end

	function automatic logic mode_valid(input logic [2:0] m);
		return m == mode_idle || m == mode_adc_nr ||
			m == mode_power_down || m == mode_standby;
	endfunction

	ctl_state_type state, next_state;
	logic [7:0] sleep_control_reg, next_sleep_control_reg;
	logic [6:0] peripheral_clock_gate_reg, next_peripheral_clock_gate_reg;
	logic [2:0] mode, next_mode;
	logic [count_width-1:0] count, next_count;
	logic [31:0] next_readdata;
	logic ack, next_ack;
	logic cpu_q, flash_q, io_q, adc_q, pll_q, osc_q, ext_q;
	logic next_cpu, next_flash, next_io, next_adc, next_pll, next_osc;
	logic next_ext;
	logic [6:0] pclk_q, next_pclk;
	logic start_q, next_start, resume_q, next_resume, rstw_q, next_rstw;
	logic sleep_allow_bit;
	logic [2:0] sleep_select_field;
	logic wake_irq;
	logic [3:0] level_ext;

	assign sleep_allow_bit = sleep_control_reg[sleep_allow_pos];
	assign sleep_select_field = sleep_control_reg[sleep_select_lsb +: 3];
	// only level-type lines that are actually asserted count in deep modes
	assign level_ext = ext_irq_pending & ext_irq_level_mode;

	// wake source filter per mode
	always_comb begin
		case (mode)
			mode_idle: wake_irq = |ext_irq_pending || power_stage_ctl_irq ||
				self_program_op_irq || adc_done_irq || watchdog_unit_irq ||
				timer_irq || other_io_irq;
			mode_adc_nr: wake_irq = |level_ext || adc_done_irq ||
				timer_irq || self_program_op_irq;
			// power-down and standby, edge irqs ignored
			default: wake_irq = |level_ext || power_stage_ctl_irq;
		endcase
	end

	// avalon slave: one wait cycle then answer
	always_comb begin
		next_ack = (avs_read || avs_write) && !ack;
		next_readdata = '0;
		next_sleep_control_reg = sleep_control_reg;
		next_peripheral_clock_gate_reg = peripheral_clock_gate_reg;
		// read data latch early so they stand at the answer edge
		if (avs_read && !ack) begin
			if (avs_address == sleep_control_off) begin
				next_readdata = {24'h00_0000, 4'h0, sleep_control_reg[3:0]};
			end else if (avs_address == peripheral_gate_off) begin
				next_readdata = {25'h000_0000, peripheral_clock_gate_reg};
			end else if (avs_address == sleep_status_off) begin
				next_readdata = {24'h00_0000, 3'h0, state};
			end
		end
		// writes commit on the answer edge, when the master sees it
		if (avs_write && ack) begin
			if (avs_address == sleep_control_off) begin
				next_sleep_control_reg = {4'h0, avs_writedata[3:0]};
			end else if (avs_address == peripheral_gate_off) begin
				next_peripheral_clock_gate_reg = avs_writedata[6:0];
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ack <= 1'b0;
			avs_readdata <= 32'h0000_0000;
			sleep_control_reg <= sleep_control_rst;
			peripheral_clock_gate_reg <= peripheral_gate_rst;
		end else begin
			ack <= next_ack;
			avs_readdata <= next_readdata;
			sleep_control_reg <= next_sleep_control_reg;
			peripheral_clock_gate_reg <= next_peripheral_clock_gate_reg;
		end
	end

	// fixed single wait state keeps readdata registered
	assign avs_waitrequest = (avs_read || avs_write) && !ack;

	// sleep sequencer
	always_comb begin
		next_state = state;
		next_mode = mode;
		next_count = count;
		next_start = 1'b0;
		next_resume = 1'b0;
		next_rstw = 1'b0;
		case (state)
			st_active: begin
				// allow bit sampled at the sleep instruction
				if (sleep_instr && sleep_allow_bit &&
					mode_valid(sleep_select_field) &&
					(sleep_select_field != mode_standby ||
					crystal_selected)) begin
					next_mode = sleep_select_field;
					next_state = st_sleep;
					// adc auto start in idle and adc nr
					next_start = adc_enabled &&
						(sleep_select_field == mode_idle ||
						sleep_select_field == mode_adc_nr);
				end
			end
			st_sleep: begin
				// reset wakes to the reset vector
				if (wake_reset) begin
					next_rstw = 1'b1;
					next_state = st_active;
				end else if (wake_irq) begin
					next_state = st_startup;
					if (mode == mode_power_down) begin
						next_count = count_width'(startup_cycles - 1);
					end else if (mode == mode_standby) begin
						next_count = count_width'(standby_wake_cycles - 1);
					end else begin
						next_count = '0;
					end
				end
			end
			st_startup: begin
				if (wake_reset) begin
					next_rstw = 1'b1;
					next_state = st_active;
				end else if (count == '0) begin
					next_count = count_width'(halt_extra_cycles - 1);
					next_state = st_halt;
				end else begin
					next_count = count - 1'b1;
				end
			end
			st_halt: begin
				if (count == '0) begin
					next_state = st_resume;
				end else begin
					next_count = count - 1'b1;
				end
			end
			st_resume: begin
				// state is kept by clock stop, never reset here
				next_resume = 1'b1;
				next_state = st_active;
			end
			default: next_state = st_active;
		endcase
	end

	// clock domain enables from the next state
	always_comb begin
		next_cpu = 1'b1;
		next_flash = 1'b1;
		next_io = 1'b1;
		next_adc = 1'b1;
		next_pll = 1'b1;
		next_osc = 1'b1;
		next_ext = 1'b0;
		if (next_state == st_sleep || next_state == st_startup) begin
			next_cpu = 1'b0;
			next_flash = 1'b0;
			case (next_mode)
				// idle keeps io, adc, pll, oscillator
				mode_idle: next_io = 1'b1;
				mode_adc_nr: begin
					next_io = 1'b0;
					next_ext = 1'b1;
				end
				mode_standby: begin
					next_io = 1'b0;
					next_adc = 1'b0;
					next_pll = 1'b0;
				end
				default: begin
					next_io = 1'b0;
					next_adc = 1'b0;
					next_pll = 1'b0;
					next_osc = 1'b0;
				end
			endcase
			// clocks restart in the last start-up cycle, oscillator too in power-down
			if (next_state == st_startup && next_count == '0) begin
				next_io = 1'b1;
				next_adc = 1'b1;
				next_pll = 1'b1;
				next_osc = 1'b1;
				next_ext = 1'b0;
			end
		end
		// only meaningful while io clock runs
		next_pclk = ~next_peripheral_clock_gate_reg & {7{next_io}};
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state <= st_active;
			mode <= mode_idle;
			count <= '0;
			start_q <= 1'b0;
			resume_q <= 1'b0;
			rstw_q <= 1'b0;
			cpu_q <= 1'b1;
			flash_q <= 1'b1;
			io_q <= 1'b1;
			adc_q <= 1'b1;
			pll_q <= 1'b1;
			osc_q <= 1'b1;
			ext_q <= 1'b0;
			pclk_q <= 7'h7f;
		end else begin
			state <= next_state;
			mode <= next_mode;
			count <= next_count;
			start_q <= next_start;
			resume_q <= next_resume;
			rstw_q <= next_rstw;
			cpu_q <= next_cpu;
			flash_q <= next_flash;
			io_q <= next_io;
			adc_q <= next_adc;
			pll_q <= next_pll;
			osc_q <= next_osc;
			ext_q <= next_ext;
			pclk_q <= next_pclk;
		end
	end

	// registered enables, latched low-phase by downstream gate cells
	assign cpu_clk_en = cpu_q;
	assign flash_clk_en = flash_q;
	assign io_clk_en = io_q;
	assign adc_clk_en = adc_q;
	assign pll_clk_en = pll_q;
	assign main_osc_en = osc_q;
	assign timer_ext_only = ext_q;
	assign periph_clk_en = pclk_q;
	assign periph_io_block = peripheral_clock_gate_reg;
	assign adc_auto_start = start_q;
	assign core_halt = state != st_active;
	assign resume_pulse = resume_q;
	assign reset_wake = rstw_q;

endmodule

// [sleep_ctl_props.sv]
/*
 * Port checker for the sleep controller.
 * Assumes it is bound to sleep_ctl and sees only that module's ports.
 */
`timescale 1ns/1ps
module sleep_ctl_props (
	input wire logic mclk, // core clock
	input wire logic rst_n, // reset, active low
	input wire logic avs_read, // read request
	input wire logic avs_write, // write request
	input wire logic avs_waitrequest, // stall
	input wire logic cpu_clk_en, // cpu clock
	input wire logic flash_clk_en, // flash clock
	input wire logic io_clk_en, // i/o clock
	input wire logic adc_clk_en, // adc clock
	input wire logic pll_clk_en, // pll clock
	input wire logic main_osc_en, // main source
	input wire logic timer_ext_only, // pin-clocked timers
	input wire logic [6:0] periph_clk_en, // peripheral clocks
	input wire logic [6:0] periph_io_block, // access block
	input wire logic adc_auto_start, // adc start pulse
	input wire logic core_halt, // core held
	input wire logic resume_pulse, // wake done
	input wire logic reset_wake // reset wake pulse
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest) else $error("bus wait too long");
	a_cpu_flash: assert property (cpu_clk_en == flash_clk_en)
		else $error("cpu and flash clocks differ");
	a_cpu_sleep: assert property (!cpu_clk_en |-> core_halt)
		else $error("cpu clock stopped while active");
	a_io_runs: assert property (io_clk_en |-> adc_clk_en && pll_clk_en
		&& main_osc_en) else $error("io clock without adc or pll");
	a_osc_off: assert property (!main_osc_en |-> !adc_clk_en
		&& !pll_clk_en && !io_clk_en) else $error("clock without source");
	a_ext_timer: assert property (timer_ext_only |-> !io_clk_en
		&& adc_clk_en) else $error("timer limit outside noise mode");
	a_gate_block: assert property ((periph_clk_en & periph_io_block)
		== 7'h0) else $error("gated peripheral clock running");
	a_resume_halt: assert property (resume_pulse |-> !core_halt
		&& $past(core_halt) && $past(core_halt, 5))
		else $error("resume without halt cycles");
	a_pulse_one: assert property (resume_pulse |=> !resume_pulse)
		else $error("resume pulse too long");
	a_reset_wake: assert property (reset_wake |-> !core_halt
		&& cpu_clk_en) else $error("reset wake left core halted");
	a_adc_start: assert property (adc_auto_start |-> ##[0:1] (core_halt
		&& adc_clk_en && !cpu_clk_en)) else $error("adc start outside sleep");
	c_resume: cover property (resume_pulse);
	c_reset: cover property (reset_wake);
	c_adc: cover property (adc_auto_start);
endmodule

bind sleep_ctl sleep_ctl_props chk (.mclk(mclk), .rst_n(rst_n),
	.avs_read(avs_read), .avs_write(avs_write),
	.avs_waitrequest(avs_waitrequest), .cpu_clk_en(cpu_clk_en),
	.flash_clk_en(flash_clk_en), .io_clk_en(io_clk_en),
	.adc_clk_en(adc_clk_en), .pll_clk_en(pll_clk_en),
	.main_osc_en(main_osc_en), .timer_ext_only(timer_ext_only),
	.periph_clk_en(periph_clk_en), .periph_io_block(periph_io_block),
	.adc_auto_start(adc_auto_start), .core_halt(core_halt),
	.resume_pulse(resume_pulse), .reset_wake(reset_wake));

// [core_model.sv]
/*
 * Core model: one sleep pulse per request, counts completed wakes.
 * Assumes the controller's clock and synchronous reset.
 */
`timescale 1ns/1ps
module core_model (
	input wire logic mclk, // core clock
	input wire logic rst_n, // reset, active low
	input wire logic go, // request a sleep instruction
	input wire logic resume_pulse, // wake done
	output logic sleep_instr, // sleep executed, one pulse
	output int resumes // completed wakes
);
	logic go_q;
	always_ff @(posedge mclk) begin
		go_q <= go;
		sleep_instr <= rst_n && go && !go_q;
		resumes <= !rst_n ? 0 : resumes + (resume_pulse === 1'b1);
	end
endmodule

// [sleep_ctl_tb.sv]
/*
 * Self-checking bench for the sleep controller.
 * Assumes core_model and the bound checker are compiled alongside.
 */
`timescale 1ns/1ps
module sleep_ctl_tb;
	import sleep_pkg::*;
	localparam int su = 20;
	logic mclk = 0, rst_n = 0, go = 0, xtal = 1, adc_en = 1;
	logic rd = 0, wr = 0, wreq, sl, cpu, fl, io, adc, pll, osc, ext;
	logic halt, res, rwake, ast;
	logic [3:0] addr = 0, lvl = 4'h1;
	logic [31:0] wd = 0, rdata, q;
	logic [10:0] wv = 0;
	logic [6:0] pce, pib;
	int failures = 0, checks = 0, starts = 0, rwakes = 0, resumes;
	int unsigned seed = 45933;
	always #2 mclk = ~mclk;
	sleep_ctl #(.startup_cycles(su)) dut (.mclk(mclk), .rst_n(rst_n),
		.avs_address(addr), .avs_read(rd), .avs_write(wr),
		.avs_writedata(wd), .avs_readdata(rdata), .avs_waitrequest(wreq),
		.sleep_instr(sl), .crystal_selected(xtal), .adc_enabled(adc_en),
		.external_irq_lines(4'h0), .ext_irq_level_mode(lvl),
		.ext_irq_pending(wv[3:0]), .power_stage_ctl_irq(wv[4]),
		.self_program_op_irq(wv[5]), .adc_done_irq(wv[6]),
		.watchdog_unit_irq(wv[7]), .timer_irq(wv[8]),
		.other_io_irq(wv[9]), .wake_reset(wv[10]), .cpu_clk_en(cpu),
		.flash_clk_en(fl), .io_clk_en(io), .adc_clk_en(adc),
		.pll_clk_en(pll), .main_osc_en(osc), .timer_ext_only(ext),
		.periph_clk_en(pce), .periph_io_block(pib), .adc_auto_start(ast),
		.core_halt(halt), .resume_pulse(res), .reset_wake(rwake));
	core_model core (.mclk(mclk), .rst_n(rst_n), .go(go),
		.resume_pulse(res), .sleep_instr(sl), .resumes(resumes));
	always @(posedge mclk) begin
		starts += (ast === 1'b1);
		rwakes += (rwake === 1'b1);
	end
	function automatic int unsigned rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// expected {cpu, flash, io, adc, pll, osc} per sleep code
	function automatic logic [5:0] exp_en(int m);
		case (m)
			0: return 6'b00_1111;
			1: return 6'b00_0111;
			2: return 6'b00_0000;
			6: return 6'b00_0001;
			default: return 6'b11_1111;
		endcase
	endfunction
	task automatic check(logic [31:0] s, logic [31:0] e);
		checks++;
		if (s !== e) begin
			failures++;
			$display("[ERR] %0t saw %h expected %h", $time, s, e);
		end
	endtask
	task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
		addr <= a;
		wd <= d;
		wr <= w;
		rd <= !w;
		do begin
			@(posedge mclk);
		end while (wreq !== 1'b0);
		q = rdata;
		wr <= 0;
		rd <= 0;
		@(posedge mclk);
	endtask
	task automatic nap(int m, logic [10:0] no, logic [10:0] yes, int d);
		int n;
		logic [6:0] g, ng;
		logic [5:0] e;
		g = 7'(rnd());
		ng = ~g;
		// no peripheral is busy while its clock is gated
		bus(1, 4'h4, {25'h0, g});
		check(pib, g);
		check(pce, ng);
		bus(1, 4'h0, (rnd() & 32'hffff_fff0) | (m << 1) | 1);
		bus(0, 4'h0, 0);
		check(q, (m << 1) | 1);
		starts = 0;
		go <= 1;
		@(posedge mclk);
		go <= 0;
		repeat (4) @(posedge mclk);
		e = exp_en(m);
		check({cpu, fl, io, adc, pll, osc}, e);
		check(pce, e[3] ? ng : 7'h0);
		check(ext, m == 1);
		bus(0, 4'h8, 0);
		check(q, 2);
		wv <= no;
		repeat (30) @(posedge mclk);
		check(halt, 1);
		// level held until the core resumes
		wv <= yes;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (res !== 1'b1 && n < 200);
		wv <= 0;
		check(n, d + 7);
		check({cpu, fl, io, adc, pll, osc}, 6'h3f);
		check(starts, m < 2);
		bus(1, 4'h4, 0);
		check(pce, 7'h7f);
		$display("sleep code %0d done", m);
	endtask
	task automatic wrap_up();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#40000;
		failures++;
		wrap_up();
	end
	initial begin
		int codes[6] = '{3, 4, 5, 7, 6, 0};
		repeat (3) @(posedge mclk);
		rst_n <= 1;
		@(posedge mclk);
		foreach (codes[i]) begin
			bus(0, 4'(codes[i] * 4), 0);
			check(q, codes[i] == 6 ? 1 : 0);
		end
		check(pce, 7'h7f);
		$display("reset values done");
		nap(0, 0, 11'h200, 1);
		nap(1, 11'h200, 11'h040, 1);
		nap(2, 11'h002, 11'h001, su);
		nap(6, 11'h040, 11'h010, standby_wake_cycles);
		check(resumes, 4);
		bus(1, 4'h0, 32'h0000_0005);
		go <= 1;
		@(posedge mclk);
		go <= 0;
		repeat (4) @(posedge mclk);
		wv <= 11'h400;
		repeat (6) @(posedge mclk);
		wv <= 0;
		check(rwakes, 1);
		check(halt, 0);
		$display("reset wake done");
		xtal <= 0;
		foreach (codes[i]) begin
			bus(1, 4'h0, (codes[i] << 1) | (i < 5));
			go <= 1;
			@(posedge mclk);
			go <= 0;
			repeat (4) @(posedge mclk);
			check({halt, cpu}, 2'b01);
		end
		$display("refusals done");
		wrap_up();
	end
endmodule
